// >>> design/usb_status_pin_logic.sv
`timescale 1ns/1ns
// usb status pin logic: shared status pins, indicator mode, apb registers
// assumes usb core levels and packet pulses synchronous to clock
module usb_status_pin_logic #(
  parameter logic [15:0] BlockId = 16'h5a31, // arbitrary value
  parameter int unsigned SlowHalf = usp_pkg::SlowHalfCycles,
  parameter int unsigned FastHalf = usp_pkg::FastHalfCycles,
  parameter int unsigned ActHold = usp_pkg::ActHoldCycles
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic usbSuspended,
  input wire logic usbConfigured,
  input wire logic txPacket,
  input wire logic [4:0] nvmLoadValue,
  output logic nvmWrEn,
  output logic [4:0] nvmWrData,
  input wire logic suspendStatusPinIn,
  output logic suspendStatusPinOut,
  output logic suspendStatusPinOe_n,
  input wire logic configStatusPinIn,
  output logic configStatusPinOut,
  output logic configStatusPinOe_n,
  output logic transmitActivityIndicator
);
  usp_nvm_if nvm ();
  logic suspOpt_r;
  logic cfgOpt_r;
  logic [2:0] modeRaw_r;
  logic [1:0] gpioOut_r;
  logic [1:0] gpioDir_r;
  logic loaded_r;
  logic wrAcc;
  logic rdAcc;
  logic mapped;
  usp_pkg::usp_mode_type mode;

  assign nvm.rdData = nvmLoadValue;
  assign nvmWrEn = nvm.wrEn;
  assign nvmWrData = nvm.wrData;

  assign pready = 1'b1;
  assign mapped = (paddr == usp_pkg::CtrlAddr) || (paddr == usp_pkg::GpioOutAddr) ||
                  (paddr == usp_pkg::GpioDirAddr) || (paddr == usp_pkg::StatusAddr) ||
                  (paddr == usp_pkg::IdAddr);
  assign pslverr = psel && penable && !mapped;
  assign wrAcc = psel && penable && pwrite && mapped && pstrb[0];
  assign rdAcc = psel && !penable && !pwrite;

  always_comb begin
    unique case (modeRaw_r)
      usp_pkg::USP_MODE_ON: mode = usp_pkg::USP_MODE_ON;
      usp_pkg::USP_MODE_TOGGLE: mode = usp_pkg::USP_MODE_TOGGLE; // [RULE10]
      usp_pkg::USP_MODE_SLOW: mode = usp_pkg::USP_MODE_SLOW;
      usp_pkg::USP_MODE_FAST: mode = usp_pkg::USP_MODE_FAST;
      default: mode = usp_pkg::USP_MODE_OFF;
    endcase
  end

  // settings come from nonvolatile storage one cycle after reset release
  always_ff @(posedge clock) begin
    if (rst) begin
      loaded_r <= 1'b0;
      suspOpt_r <= 1'b0;
      cfgOpt_r <= 1'b0;
      modeRaw_r <= usp_pkg::ModeReset;
    end else if (!loaded_r) begin
      loaded_r <= 1'b1;
      suspOpt_r <= nvm.rdData[usp_pkg::CtrlSuspBit];
      cfgOpt_r <= nvm.rdData[usp_pkg::CtrlCfgBit];
      modeRaw_r <= nvm.rdData[usp_pkg::NvmModeLsb +: usp_pkg::ModeWidth]; // [RULE9]
    end else if (wrAcc && paddr == usp_pkg::CtrlAddr) begin
      suspOpt_r <= pwdata[usp_pkg::CtrlSuspBit];
      cfgOpt_r <= pwdata[usp_pkg::CtrlCfgBit];
      modeRaw_r <= pwdata[usp_pkg::CtrlModeLsb +: usp_pkg::ModeWidth]; // [RULE10]
    end
  end

  // every control write is saved so the choice survives power cycles
  always_comb begin
    nvm.wrEn = loaded_r && wrAcc && (paddr == usp_pkg::CtrlAddr); // [RULE9]
    nvm.wrData = {pwdata[usp_pkg::CtrlModeLsb +: usp_pkg::ModeWidth],
                  pwdata[usp_pkg::CtrlCfgBit], pwdata[usp_pkg::CtrlSuspBit]};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      gpioOut_r <= usp_pkg::GpioOutReset;
      gpioDir_r <= usp_pkg::GpioDirReset;
    end else if (wrAcc && paddr == usp_pkg::GpioOutAddr) begin
      gpioOut_r <= pwdata[usp_pkg::GpioWidth-1:0];
    end else if (wrAcc && paddr == usp_pkg::GpioDirAddr) begin
      gpioDir_r <= pwdata[usp_pkg::GpioWidth-1:0];
    end
  end

  // pins registered once per clock
  always_ff @(posedge clock) begin
    if (rst) begin
      suspendStatusPinOut <= 1'b0;
      suspendStatusPinOe_n <= 1'b1;
    end else if (suspOpt_r) begin
      suspendStatusPinOut <= !usbSuspended; // [RULE1] [RULE2] [RULE3] [RULE12]
      suspendStatusPinOe_n <= 1'b0;
    end else begin
      suspendStatusPinOut <= gpioOut_r[0]; // [RULE4]
      suspendStatusPinOe_n <= gpioDir_r[0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      configStatusPinOut <= 1'b0; // [RULE5]
      configStatusPinOe_n <= 1'b1;
    end else if (cfgOpt_r) begin
      configStatusPinOut <= usbConfigured; // [RULE6] [RULE7] [RULE12]
      configStatusPinOe_n <= 1'b0;
    end else begin
      configStatusPinOut <= gpioOut_r[1]; // [RULE8]
      configStatusPinOe_n <= gpioDir_r[1];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (rdAcc) begin
      unique case (paddr)
        usp_pkg::CtrlAddr: prdata <= {25'h0, modeRaw_r, 2'h0, cfgOpt_r, suspOpt_r};
        usp_pkg::GpioOutAddr: prdata <= {30'h0, gpioOut_r};
        usp_pkg::GpioDirAddr: prdata <= {30'h0, gpioDir_r};
        usp_pkg::StatusAddr: prdata <= {26'h0, transmitActivityIndicator, usbConfigured,
                                        usbSuspended, loaded_r, configStatusPinIn,
                                        suspendStatusPinIn};
        usp_pkg::IdAddr: prdata <= {16'h0, BlockId};
        default: prdata <= 32'h0;
      endcase
    end
  end

  usp_flash_gen #(
    .SlowHalf(SlowHalf),
    .FastHalf(FastHalf),
    .ActHold(ActHold)
  ) u_flash (
    .clock(clock),
    .rst(rst),
    .mode(mode),
    .txPacket(txPacket),
    .ledOut(transmitActivityIndicator)
  );
endmodule

// >>> design/usp_pkg.sv
// usb status pin logic: shared constants, mode codes, register map
// assumes a 10 MHz device clock and an apb slave port with 32-bit data
// Function
// RULE1 - suspend option on: pin low in suspend
// RULE2 - suspend option on: pin high on resume
// RULE3 - option one: pin mirrors suspend state
// RULE4 - option zero: pin is plain gpio
// RULE5 - config option on: pin low after reset
// RULE6 - config option on: high once host configures
// RULE7 - option one: pin shows configuration state
// RULE8 - option zero: config pin is plain gpio
// RULE9 - transmit indicator mode kept in nonvolatile storage
// RULE10 - modes: off 0, on 1, toggle 3, slow 4, fast 5
// RULE11 - toggle per packet, flash while transmitting
// RULE12 - status inputs synchronous, pin outputs registered
package usp_pkg;
  localparam int unsigned ClockHz = 10_000_000;
  localparam int unsigned SlowPeriodMs = 500;
  localparam int unsigned FastPeriodMs = 100;
  localparam int unsigned SlowHalfCycles = ClockHz / 1000 * SlowPeriodMs / 2;
  localparam int unsigned FastHalfCycles = ClockHz / 1000 * FastPeriodMs / 2;
  localparam int unsigned ActHoldMs = 200;
  localparam int unsigned ActHoldCycles = ClockHz / 1000 * ActHoldMs;

  typedef enum logic [2:0] {
    USP_MODE_OFF = 3'h0,
    USP_MODE_ON = 3'h1,
    USP_MODE_TOGGLE = 3'h3,
    USP_MODE_SLOW = 3'h4,
    USP_MODE_FAST = 3'h5
  } usp_mode_type;

  localparam logic [11:0] CtrlAddr = 12'h000;
  localparam logic [11:0] GpioOutAddr = 12'h004;
  localparam logic [11:0] GpioDirAddr = 12'h008;
  localparam logic [11:0] StatusAddr = 12'h00c;
  localparam logic [11:0] IdAddr = 12'h010;

  localparam int unsigned CtrlSuspBit = 0;
  localparam int unsigned CtrlCfgBit = 1;
  localparam int unsigned CtrlModeLsb = 4;
  localparam int unsigned ModeWidth = 3;
  localparam int unsigned NvmModeLsb = 2;
  localparam int unsigned GpioWidth = 2;

  localparam logic [2:0] ModeReset = 3'h0;
  localparam logic [1:0] GpioOutReset = 2'h0;
  localparam logic [1:0] GpioDirReset = 2'h3;
endpackage

// >>> design/usp_nvm_if.sv
`timescale 1ns/1ns
// usb status pin logic: nonvolatile storage port for the saved settings
// assumes the storage loads its value at reset and accepts single-cycle writes
interface usp_nvm_if;
  logic wrEn;
  logic [4:0] wrData;
  logic [4:0] rdData;
  modport ctl (output wrEn, output wrData, input rdData);
  modport mem (input wrEn, input wrData, output rdData);
endinterface

// >>> design/usp_flash_gen.sv
`timescale 1ns/1ns
// usb status pin logic: transmit activity indicator generator
// assumes packet pulses are one cycle and synchronous to clock
module usp_flash_gen #(
  parameter int unsigned SlowHalf = usp_pkg::SlowHalfCycles,
  parameter int unsigned FastHalf = usp_pkg::FastHalfCycles,
  parameter int unsigned ActHold = usp_pkg::ActHoldCycles
) (
  input wire logic clock,
  input wire logic rst,
  input wire usp_pkg::usp_mode_type mode,
  input wire logic txPacket,
  output logic ledOut
);
  logic [31:0] phaseCnt_r;
  logic [31:0] actCnt_r;
  logic toggle_r;
  logic blink_r;
  logic active;
  logic [31:0] halfLim;

  assign active = (actCnt_r != 32'h0);
  assign halfLim = (mode == usp_pkg::USP_MODE_FAST) ? FastHalf : SlowHalf;

  // activity window restarts on every packet
  always_ff @(posedge clock) begin
    if (rst) begin
      actCnt_r <= 32'h0;
    end else if (txPacket) begin
      actCnt_r <= ActHold;
    end else if (active) begin
      actCnt_r <= actCnt_r - 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      toggle_r <= 1'b0;
    end else if (txPacket) begin
      toggle_r <= ~toggle_r; // [RULE11]
    end
  end

  // flash phase runs only during activity
  always_ff @(posedge clock) begin
    if (rst || !active) begin
      phaseCnt_r <= 32'h0;
      blink_r <= 1'b0;
    end else if (phaseCnt_r + 32'h1 >= halfLim) begin
      phaseCnt_r <= 32'h0;
      blink_r <= ~blink_r; // [RULE11]
    end else begin
      phaseCnt_r <= phaseCnt_r + 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ledOut <= 1'b0;
    end else begin
      unique case (mode)
        usp_pkg::USP_MODE_OFF: ledOut <= 1'b0;
        usp_pkg::USP_MODE_ON: ledOut <= 1'b1;
        usp_pkg::USP_MODE_TOGGLE: ledOut <= toggle_r;
        usp_pkg::USP_MODE_SLOW,
        usp_pkg::USP_MODE_FAST: ledOut <= blink_r;
        default: ledOut <= 1'b0;
      endcase
    end
  end
endmodule

// >>> dv/usp_far_model.sv
`timescale 1ns/1ns
// usb status pin logic: far side model, settings storage and pin loads
// assumes weak pull-downs on both pins and storage writes on the clock edge
module usp_far_model #(
  parameter logic [4:0] InitValue = 5'h03
) (
  input wire logic clock,
  input wire logic nvmWrEn,
  input wire logic [4:0] nvmWrData,
  output logic [4:0] nvmLoadValue,
  input wire logic suspendStatusPinOut,
  input wire logic suspendStatusPinOe_n,
  input wire logic configStatusPinOut,
  input wire logic configStatusPinOe_n,
  output logic suspendStatusPinIn,
  output logic configStatusPinIn
);
  logic [4:0] storedValue = InitValue;
  // stored settings outlive a reset of the block
  always @(posedge clock) if (nvmWrEn) storedValue <= nvmWrData;
  assign nvmLoadValue = storedValue;
  // a released pin falls to the pull-down level
  assign suspendStatusPinIn = !suspendStatusPinOe_n && suspendStatusPinOut;
  assign configStatusPinIn = !configStatusPinOe_n && configStatusPinOut;
endmodule

// >>> dv/usp_status_properties.sv
`timescale 1ns/1ns
// usb status pin logic: port assertions for apb, storage and pins
// assumes it is bound to the top module and sees its ports only
module usp_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic nvmWrEn,
  input wire logic [4:0] nvmWrData,
  input wire logic suspendStatusPinOut,
  input wire logic suspendStatusPinOe_n,
  input wire logic configStatusPinOut,
  input wire logic configStatusPinOe_n,
  input wire logic transmitActivityIndicator
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ready_always_a: assert property (pready)
    else $error("pready low");
  err_unmapped_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
    else $error("no error on unmapped access");
  err_access_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access phase");
  store_write_a: assert property (nvmWrEn |->
    psel && penable && pwrite && paddr == 12'h000)
    else $error("storage write without control write");
  store_data_a: assert property (nvmWrEn |-> nvmWrData == {pwdata[6:4], pwdata[1:0]})
    else $error("storage data wrong");
  cfg_reset_a: assert property ($past(rst) |->
    !configStatusPinOut && configStatusPinOe_n)
    else $error("config pin not low after reset");
  susp_reset_a: assert property ($past(rst) |->
    !suspendStatusPinOut && suspendStatusPinOe_n)
    else $error("suspend pin not idle after reset");
  ind_reset_a: assert property ($past(rst) |-> !transmitActivityIndicator)
    else $error("indicator not off after reset");
  cover property (nvmWrEn);
  cover property (pslverr);
  cover property ($rose(configStatusPinOut));
endmodule
bind usb_status_pin_logic usp_checker usp_checker_i (.clock, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pready, .pslverr, .nvmWrEn, .nvmWrData, .suspendStatusPinOut,
  .suspendStatusPinOe_n, .configStatusPinOut, .configStatusPinOe_n, .transmitActivityIndicator);

// >>> dv/tb_usb_status_pin_logic.sv
`timescale 1ns/1ns
// usb status pin logic: apb directed tests of status pins and indicator
// assumes the far model holds settings 5'h03 at start
module tb_usb_status_pin_logic;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, usbSuspended, usbConfigured;
  logic txPacket, nvmWrEn, suspendStatusPinIn, suspendStatusPinOut, suspendStatusPinOe_n;
  logic configStatusPinIn, configStatusPinOut, configStatusPinOe_n, transmitActivityIndicator;
  logic e, t0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [4:0] nvmLoadValue, nvmWrData;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  // block id value is arbitrary
  usb_status_pin_logic #(.BlockId(16'h2c7e), .SlowHalf(8), .FastHalf(3), .ActHold(40))
    usb_status_pin_logic_i (.clock, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .usbSuspended,
    .usbConfigured, .txPacket, .nvmLoadValue, .nvmWrEn, .nvmWrData, .suspendStatusPinIn,
    .suspendStatusPinOut, .suspendStatusPinOe_n, .configStatusPinIn, .configStatusPinOut,
    .configStatusPinOe_n, .transmitActivityIndicator);
  usp_far_model usp_far_model_i (.clock, .nvmWrEn, .nvmWrData, .nvmLoadValue,
    .suspendStatusPinOut, .suspendStatusPinOe_n, .configStatusPinOut, .configStatusPinOe_n,
    .suspendStatusPinIn, .configStatusPinIn);
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      results();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, usbSuspended, usbConfigured, txPacket} = '0;
    pstrb = 4'hf;
    rst = 1'b1;
    tick(10);
    rst <= 1'b0;
    tick(3);
    chk({configStatusPinOe_n, configStatusPinOut}, 32'h0);
    chk(suspendStatusPinOut, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h3);
    apb(1'b0, 12'h010, 32'h0);
    chk(q, 32'h2c7e);
    apb(1'b0, 12'h020, 32'h0);
    chk(q, 32'h0);
    chk(e, 32'h1);
    usbSuspended <= 1'b1;
    usbConfigured <= 1'b1;
    tick(2);
    chk({suspendStatusPinOut, configStatusPinOut}, 32'h1);
    usbSuspended <= 1'b0;
    tick(2);
    chk({suspendStatusPinOut, configStatusPinOut}, 32'h3);
    apb(1'b1, 12'h004, 32'h3);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h000, 32'h40);
    usbSuspended <= 1'b1;
    usbConfigured <= 1'b0;
    tick(2);
    chk({suspendStatusPinOe_n, suspendStatusPinOut}, 32'h1);
    chk({configStatusPinOe_n, configStatusPinOut}, 32'h1);
    chk(transmitActivityIndicator, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk(q, 32'h0f);
    pstrb <= 4'h0;
    apb(1'b1, 12'h004, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h3);
    apb(1'b1, 12'h000, 32'h50);
    tick(3);
    chk(transmitActivityIndicator, 32'h0);
    apb(1'b1, 12'h000, 32'h10);
    tick(3);
    chk(transmitActivityIndicator, 32'h1);
    apb(1'b1, 12'h000, 32'h20);
    tick(3);
    chk(transmitActivityIndicator, 32'h0);
    apb(1'b1, 12'h000, 32'h33);
    tick(3);
    t0 = transmitActivityIndicator;
    txPacket <= 1'b1;
    tick(1);
    txPacket <= 1'b0;
    tick(4);
    chk(transmitActivityIndicator, !t0);
    tick(45);
    apb(1'b1, 12'h000, 32'h50);
    txPacket <= 1'b1;
    tick(1);
    txPacket <= 1'b0;
    tick(6);
    chk(transmitActivityIndicator, 32'h1);
    tick(3);
    chk(transmitActivityIndicator, 32'h0);
    tick(50);
    chk(transmitActivityIndicator, 32'h0);
    apb(1'b1, 12'h000, 32'h51);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(2);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h51);
    results();
  end
endmodule
